// file: mosd_defines.svh
// register offsets, field positions, reset values and timing counts
//
// Notes on behaviour
// R1: detection runs only while detect enable set
// R2: stop detection guaranteed only from 2 MHz
// R3: select bit chooses reset or interrupt
// R4: reset mode: stop initialises then halts device
// R5: halt ends on hardware or monitor-0 reset
// R6: software avoids enabling reset mode while stopped
// R7: interrupt-mode stop selects on-chip source
// R8: sub clock CPU select never touched
// R9: on-chip select forces slow oscillator on
// R10: software keeps fast oscillator enabled when chosen
// R11: stop sets interrupt, flag, stopped status
// R12: restart sets interrupt, flag, clears stopped
// R13: flag blocks interrupts until software clears
// R14: interrupt is non-maskable
// R15: shares vector with watchdog, monitors 1, 2
// R16: handler reads flags then clears detect flag
// R17: software switches back to main clock
// R18: main clock output: direct, by 8, by 32
// R19: sub clock output with field 01b
// R20: software unlocks protect before clock changes
// R21: software keeps output below bus clock
// R22: external main clock keeps running
// R23: lock bit freezes detect enable and source
// R24: detector independent of main clock
`ifndef MOSD_DEFINES_SVH
`define MOSD_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MOSD_ADDR_CLKCTL0 8'h00
`define MOSD_ADDR_CLKCTL1 8'h04
`define MOSD_ADDR_DETCTL  8'h08
`define MOSD_ADDR_PCLKSEL 8'h0C
`define MOSD_ADDR_PROTECT 8'h10
`define MOSD_ADDR_LOCK    8'h14
`define MOSD_ADDR_FASTOSC 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MOSD_F_OUTFIELD   1:0
`define MOSD_F_SUBCPU     7
`define MOSD_F_SLOWOFF    4
`define MOSD_F_DETEN      0
`define MOSD_F_ONCHIP     1
`define MOSD_F_DETFLAG    2
`define MOSD_F_STOPPED    3
`define MOSD_F_IRQSEL     7
`define MOSD_F_OUTMAIN    5
`define MOSD_F_UNLOCK     0
`define MOSD_F_CHGLOCK    0
`define MOSD_F_FASTEN     0
`define MOSD_F_FASTCHOICE 1

// ----------------------------------------------------------------
// reset values and output field codes
// ----------------------------------------------------------------
`define MOSD_RST_ONCHIP   1'b1
`define MOSD_OUT_MAIN     2'h0
`define MOSD_OUT_SUB      2'h1
`define MOSD_OUT_DIV8     2'h2
`define MOSD_OUT_DIV32    2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MOSD_CLK_MHZ      25
`define MOSD_MIN_MAIN_MHZ 2
`define MOSD_QUIET_CYC    ((`MOSD_CLK_MHZ + `MOSD_MIN_MAIN_MHZ - 1) / `MOSD_MIN_MAIN_MHZ)
`define MOSD_QUIET_W      5

`endif

// file: mosd_pkg.sv
// types shared by the oscillator stop/restart detector
`include "mosd_defines.svh"
package mosd_pkg;

   // physical state of the main oscillator as seen by the detector
   typedef enum logic {MOSD_RUN, MOSD_STOP} mosd_osc_t;

   // state of the activity watcher
   typedef struct packed {
      logic                     prev;
      logic [`MOSD_QUIET_W-1:0] cnt;
   } mosd_act_t;

   // state of the detector top
   typedef struct packed {
      mosd_osc_t  osc;
      logic       halted;
      logic       detEn;
      logic       irqSel;
      logic       onchipSel;
      logic       detFlag;
      logic       stopped;
      logic       slowOff;
      logic       fastEn;
      logic       fastChoice;
      logic       subCpu;
      logic [1:0] outField;
      logic       outMain;
      logic       unlock;
      logic       chgLock;
      logic       irq;
      logic       clock_output_pin;
      logic [4:0] div;
      logic [7:0] rdData;
   } mosd_state_t;

endpackage

// file: mosd_activity.sv
// watches the main oscillator input for edges and long silence
`timescale 1ns/100ps
`include "mosd_defines.svh"
module mosd_activity
   import mosd_pkg::*;
#(
   parameter int QUIET_CYC = `MOSD_QUIET_CYC
)(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // oscillator
   input  wire logic oscIn,
   // activity
   output logic      edgeSeen,
   output logic      quiet
);

   localparam logic [`MOSD_QUIET_W-1:0] QLIM = `MOSD_QUIET_W'(QUIET_CYC);

   mosd_act_t s;
   mosd_act_t next_s;

   // ----------------------------------------------------------------
   // edge and silence counter
   // ----------------------------------------------------------------

   // runs on the system clock, never on the watched oscillator
   always_comb begin // R24
      next_s      = s;
      next_s.prev = oscIn;
      if (oscIn && !s.prev)
         next_s.cnt = '0;
      else if (s.cnt != QLIM)
         next_s.cnt = s.cnt + 1'b1;
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end

   // silence longer than one period of the slowest usable clock
   assign edgeSeen = oscIn && !s.prev;
   assign quiet    = (s.cnt == QLIM); // R2

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_edge_clears_quiet: assert property ( // R2
      edgeSeen |=> !quiet [*2])
      else $error("quiet shortly after an edge");
   a_quiet_needs_gap: assert property ( // R24
      $rose(quiet) |-> !$past(edgeSeen, 1) && !$past(edgeSeen, 2))
      else $error("quiet raised without a silent gap");

endmodule

// file: mosd_detector.sv
// main oscillator stop/restart detector with clock select registers
`timescale 1ns/100ps
`include "mosd_defines.svh"
module mosd_detector
   import mosd_pkg::*;
#(
   parameter int QUIET_CYC = `MOSD_QUIET_CYC
)(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // register port
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRData,
   // clock sources and other reset/interrupt sources
   input  wire logic       mainOscIn,
   input  wire logic       subClkIn,
   input  wire logic       voltMon0Rst,
   input  wire logic       wdtIrq,
   input  wire logic       voltMon1Irq,
   input  wire logic       voltMon2Irq,
   // reset and interrupt requests
   output logic            oscStopReset,
   output logic            oscNmi,
   output logic            sharedNmi,
   // clock generator controls
   output logic            clockOutPin,
   output logic            onchipSourceSelect,
   output logic            slowOscOff,
   output logic            fastOscEnable,
   output logic            fastOscChoice,
   output logic            subClockCpuSelect,
   output logic            mainClockStopped
);

   localparam mosd_state_t RST_STATE = '{
      osc:        MOSD_RUN,
      halted:     1'b0,
      detEn:      1'b0,
      irqSel:     1'b0,
      onchipSel:  `MOSD_RST_ONCHIP,
      detFlag:    1'b0,
      stopped:    1'b0,
      slowOff:    1'b0,
      fastEn:     1'b0,
      fastChoice: 1'b0,
      subCpu:     1'b0,
      outField:   2'h0,
      outMain:    1'b0,
      unlock:     1'b0,
      chgLock:    1'b0,
      irq:        1'b0,
      clock_output_pin:     1'b0,
      div:        5'h00,
      rdData:     8'h00
   };

   mosd_state_t s;
   mosd_state_t next_s;
   logic        edgeSeen;
   logic        quiet;
   logic        stopEv;
   logic        restartEv;
   logic        wrOk;
   logic        mainSel;

   // ----------------------------------------------------------------
   // oscillator activity
   // ----------------------------------------------------------------

   // watcher runs on the system clock so a dead main clock is seen
   mosd_activity #(
      .QUIET_CYC (QUIET_CYC)
   ) uActivity (
      .clk      (clk),
      .rst      (rst),
      .oscIn    (mainOscIn),
      .edgeSeen (edgeSeen),
      .quiet    (quiet)
   );

   // stop and restart events from the physical oscillator state
   assign stopEv    = quiet && (s.osc == MOSD_RUN);
   assign restartEv = edgeSeen && (s.osc == MOSD_STOP);
   assign wrOk      = regWr && s.unlock;
   assign mainSel   = !s.subCpu && !s.onchipSel;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------

   // register access, detection, clock output, halt handling
   always_comb begin
      logic      holdHalt;
      mosd_osc_t holdOsc;
      holdHalt      = 1'b0;
      holdOsc       = MOSD_RUN;
      next_s        = s;
      next_s.irq    = 1'b0;
      next_s.rdData = 8'h00;

      // read data, unmapped offsets read as zero
      if (regRd) begin
         if (regAddr == `MOSD_ADDR_CLKCTL0) begin
            next_s.rdData[`MOSD_F_OUTFIELD] = s.outField;
            next_s.rdData[`MOSD_F_SUBCPU]   = s.subCpu;
         end else if (regAddr == `MOSD_ADDR_CLKCTL1) begin
            next_s.rdData[`MOSD_F_SLOWOFF] = s.slowOff;
         end else if (regAddr == `MOSD_ADDR_DETCTL) begin
            next_s.rdData[`MOSD_F_DETEN]   = s.detEn;
            next_s.rdData[`MOSD_F_ONCHIP]  = s.onchipSel;
            next_s.rdData[`MOSD_F_DETFLAG] = s.detFlag;
            next_s.rdData[`MOSD_F_STOPPED] = s.stopped;
            next_s.rdData[`MOSD_F_IRQSEL]  = s.irqSel;
         end else if (regAddr == `MOSD_ADDR_PCLKSEL) begin
            next_s.rdData[`MOSD_F_OUTMAIN] = s.outMain;
         end else if (regAddr == `MOSD_ADDR_PROTECT) begin
            next_s.rdData[`MOSD_F_UNLOCK] = s.unlock;
         end else if (regAddr == `MOSD_ADDR_LOCK) begin
            next_s.rdData[`MOSD_F_CHGLOCK] = s.chgLock;
         end else if (regAddr == `MOSD_ADDR_FASTOSC) begin
            next_s.rdData[`MOSD_F_FASTEN]     = s.fastEn;
            next_s.rdData[`MOSD_F_FASTCHOICE] = s.fastChoice;
         end
      end

      // writes; clock registers only while the protect is released
      if (regWr && regAddr == `MOSD_ADDR_PROTECT) begin
         next_s.unlock = regWData[`MOSD_F_UNLOCK];
      end else if (regWr && regAddr == `MOSD_ADDR_LOCK) begin
         next_s.chgLock = regWData[`MOSD_F_CHGLOCK];
      end else if (wrOk && regAddr == `MOSD_ADDR_CLKCTL0) begin
         next_s.outField = regWData[`MOSD_F_OUTFIELD];
         if (!s.chgLock)
            next_s.subCpu = regWData[`MOSD_F_SUBCPU]; // R23
      end else if (wrOk && regAddr == `MOSD_ADDR_CLKCTL1) begin
         next_s.slowOff = regWData[`MOSD_F_SLOWOFF];
      end else if (wrOk && regAddr == `MOSD_ADDR_DETCTL) begin
         next_s.irqSel    = regWData[`MOSD_F_IRQSEL];
         next_s.onchipSel = regWData[`MOSD_F_ONCHIP];
         if (!s.chgLock)
            next_s.detEn = regWData[`MOSD_F_DETEN]; // R23
         if (!regWData[`MOSD_F_DETFLAG])
            next_s.detFlag = 1'b0; // R13
      end else if (wrOk && regAddr == `MOSD_ADDR_PCLKSEL) begin
         next_s.outMain = regWData[`MOSD_F_OUTMAIN];
      end else if (wrOk && regAddr == `MOSD_ADDR_FASTOSC) begin
         next_s.fastEn     = regWData[`MOSD_F_FASTEN];
         next_s.fastChoice = regWData[`MOSD_F_FASTCHOICE];
      end

      // oscillator state follows the pin whatever the enable
      if (stopEv)
         next_s.osc = MOSD_STOP;
      else if (restartEv)
         next_s.osc = MOSD_RUN;

      // detection acts only when enabled; the sub clock select and
      // the fast oscillator bits are left alone
      if (s.detEn && (stopEv || restartEv)) begin // R1 R8
         if (!s.irqSel) begin
            next_s.halted = 1'b1; // R3 R4
         end else begin
            next_s.slowOff = 1'b0; // R11 R12
            next_s.stopped = stopEv; // R11 R12
            if (stopEv)
               next_s.onchipSel = 1'b1; // R7
            if (!s.detFlag)
               next_s.irq = 1'b1; // R3 R13
            next_s.detFlag = 1'b1; // R11 R12 R13
         end
      end

      // on-chip source always runs with the slow oscillator on
      if (next_s.onchipSel)
         next_s.slowOff = 1'b0; // R9

      // divider counts main oscillator rising edges
      if (edgeSeen)
         next_s.div = s.div + 5'h01;

      // clock output source select
      next_s.clock_output_pin = 1'b0;
      if (mainSel && s.outMain && s.outField == `MOSD_OUT_MAIN)
         next_s.clock_output_pin = mainOscIn; // R18
      else if (mainSel && !s.outMain && s.outField == `MOSD_OUT_DIV8)
         next_s.clock_output_pin = s.div[2]; // R18
      else if (mainSel && !s.outMain && s.outField == `MOSD_OUT_DIV32)
         next_s.clock_output_pin = s.div[4]; // R18
      else if (s.subCpu && !s.outMain && s.outField == `MOSD_OUT_SUB)
         next_s.clock_output_pin = subClkIn; // R19

      // halted device is held initialised until monitor-0 reset
      if (s.halted || voltMon0Rst) begin // R4 R5
         holdHalt      = next_s.halted && !voltMon0Rst;
         holdOsc       = next_s.osc;
         next_s        = RST_STATE;
         next_s.halted = holdHalt;
         next_s.osc    = holdOsc;
      end
   end

   // state register, hardware reset releases the halt
   always_ff @(posedge clk) begin
      if (rst)
         s <= RST_STATE; // R5
      else
         s <= next_s;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------

   // requests; the shared vector merges the other sources
   assign oscStopReset       = s.halted;
   assign oscNmi             = s.irq; // R14
   assign sharedNmi          = s.irq | wdtIrq | voltMon1Irq | voltMon2Irq; // R15
   assign regRData           = s.rdData;
   assign clockOutPin        = s.clock_output_pin;
   assign onchipSourceSelect = s.onchipSel;
   assign slowOscOff         = s.slowOff;
   assign fastOscEnable      = s.fastEn;
   assign fastOscChoice      = s.fastChoice;
   assign subClockCpuSelect  = s.subCpu;
   assign mainClockStopped   = s.stopped;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence seqIrqStop;
      stopEv && s.detEn && s.irqSel && !s.halted && !voltMon0Rst;
   endsequence

   sequence seqIrqRestart;
      restartEv && s.detEn && s.irqSel && !s.halted && !voltMon0Rst;
   endsequence

   sequence seqSwitched;
      s.onchipSel && !s.slowOff && s.stopped && s.detFlag;
   endsequence

   a_irq_needs_enable: assert property ( // R1
      s.irq |-> $past(s.detEn) && $past(s.irqSel))
      else $error("interrupt without detect enable");
   a_reset_mode_halt: assert property ( // R4
      stopEv && s.detEn && !s.irqSel && !voltMon0Rst
      |=> oscStopReset [*3])
      else $error("reset mode did not halt");
   a_halt_release: assert property ( // R5
      $fell(s.halted) |-> $past(voltMon0Rst) || $past(rst))
      else $error("halt left without reset");
   a_stop_switches: assert property ( // R11
      seqIrqStop |=> seqSwitched)
      else $error("stop did not switch to on-chip");
   a_restart_status: assert property ( // R12
      seqIrqRestart |=> !s.stopped && s.detFlag && !s.slowOff)
      else $error("restart status wrong");
   a_flag_with_irq: assert property ( // R13
      oscNmi |-> s.detFlag && !$past(s.detFlag))
      else $error("interrupt without fresh detect flag");
   a_flag_blocks_irq: assert property ( // R13
      s.detFlag |=> !oscNmi)
      else $error("interrupt while flag set");
   a_onchip_slow_on: assert property ( // R9
      onchipSourceSelect |-> !slowOscOff)
      else $error("slow oscillator off with on-chip source");
   a_lock_keeps_en: assert property ( // R23
      regWr && s.chgLock && !s.halted && !voltMon0Rst
      |=> $stable(s.detEn) && $stable(s.subCpu))
      else $error("locked bit changed");
   a_sub_untouched: assert property ( // R8
      !regWr && !s.halted && !voltMon0Rst |=> $stable(s.subCpu))
      else $error("sub clock select changed by hardware");

   // detection outcomes and the shared interrupt vector
   a_irq_mode_nmi: assert property ( // R3 R14
      stopEv && s.detEn && s.irqSel && !s.detFlag && !s.halted
      && !voltMon0Rst |=> oscNmi)
      else $error("no interrupt on detected stop");
   a_keeps_fast_bits: assert property ( // R10
      (stopEv || restartEv) && s.detEn && !regWr && !s.halted
      && !voltMon0Rst |=> $stable(s.fastEn) && $stable(s.fastChoice))
      else $error("fast oscillator bits changed by detection");
   a_shared_vector: assert property ( // R15
      wdtIrq || voltMon1Irq || voltMon2Irq || oscNmi |-> sharedNmi)
      else $error("shared request missing a source");

   // clock output follows the selected source one cycle late
   a_out_main_direct: assert property ( // R18
      mainSel && s.outMain && s.outField == `MOSD_OUT_MAIN && !s.halted
      && !voltMon0Rst |=> clockOutPin == $past(mainOscIn))
      else $error("clock output not the main clock");
   a_out_div_eight: assert property ( // R18
      mainSel && !s.outMain && s.outField == `MOSD_OUT_DIV8 && !s.halted
      && !voltMon0Rst |=> clockOutPin == $past(s.div[2]))
      else $error("clock output not main clock by 8");
   a_out_sub_clock: assert property ( // R19
      s.subCpu && !s.outMain && s.outField == `MOSD_OUT_SUB && !s.halted
      && !voltMon0Rst |=> clockOutPin == $past(subClkIn))
      else $error("clock output not the sub clock");

endmodule

// file: mosd_detector_tb.sv
// self-checking testbench for the oscillator stop/restart detector
`timescale 1ns/100ps
module mosd_detector_tb
   import mosd_pkg::*;
;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   typedef struct {
      logic [7:0] addr;
      logic [7:0] wd;
      logic [7:0] exp;
   } mosd_tbrow_t;
   logic       clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
   logic [7:0] regAddr = 8'h00, regWData = 8'h00, regRData;
   logic       mainOscIn = 1'b0, subClkIn = 1'b0, voltMon0Rst = 1'b0;
   logic       wdtIrq = 1'b0, voltMon1Irq = 1'b0, voltMon2Irq = 1'b0;
   logic       oscStopReset, oscNmi, sharedNmi, clockOutPin;
   logic       onchipSourceSelect, slowOscOff, fastOscEnable;
   logic       fastOscChoice, subClockCpuSelect, mainClockStopped;
   logic       oscRun = 1'b1;
   logic [1:0] subDiv = 2'h0;
   int         error_cnt = 0, n_checks = 0, nmiCnt = 0, n;
   logic [7:0] d;
   mosd_tbrow_t rows[10];

   mosd_detector #(.QUIET_CYC(4)) mosd_detector_inst (
      .clk(clk), .rst(rst), .regAddr(regAddr), .regWData(regWData),
      .regWr(regWr), .regRd(regRd), .regRData(regRData),
      .mainOscIn(mainOscIn), .subClkIn(subClkIn),
      .voltMon0Rst(voltMon0Rst), .wdtIrq(wdtIrq),
      .voltMon1Irq(voltMon1Irq), .voltMon2Irq(voltMon2Irq),
      .oscStopReset(oscStopReset), .oscNmi(oscNmi), .sharedNmi(sharedNmi),
      .clockOutPin(clockOutPin), .onchipSourceSelect(onchipSourceSelect),
      .slowOscOff(slowOscOff), .fastOscEnable(fastOscEnable),
      .fastOscChoice(fastOscChoice), .subClockCpuSelect(subClockCpuSelect),
      .mainClockStopped(mainClockStopped));

   // ----------------------------------------------------------------
   // clocks and sources
   // ----------------------------------------------------------------
   // 25 MHz system clock
   always #20 clk = ~clk;
   // main oscillator toggles every cycle while running, freezes when stopped
   always @(posedge clk) begin
      if (oscRun) mainOscIn <= ~mainOscIn;
      subDiv <= subDiv + 2'h1;
      if (subDiv == 2'h3) subClkIn <= ~subClkIn; // sub clock, 8-cycle period
      if (oscNmi === 1'b1) nmiCnt <= nmiCnt + 1;  // count interrupt pulses
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWData <= v;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRData;
   endtask

   // run or stop the main oscillator, then wait a span
   task automatic osc(input logic on, input int cyc);
      @(posedge clk);
      oscRun <= on;
      repeat (cyc) @(posedge clk);
      #1;
   endtask

   // count rising edges of the clock output over 64 cycles
   task automatic rises(output int cnt);
      logic p;
      cnt = 0;
      p = clockOutPin;
      repeat (64) begin
         @(posedge clk);
         #1 if (clockOutPin && !p) cnt++;
         p = clockOutPin;
      end
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog against a hung run
   initial begin
      repeat (5000) @(posedge clk);
      error_cnt++;
      summarize();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      // on-chip select is cleared before slow-off can be written
      rows = '{'{8'h00, 8'h82, 8'h82}, '{8'h00, 8'h01, 8'h01},
               '{8'h08, 8'h80, 8'h80}, '{8'h08, 8'h00, 8'h00},
               '{8'h04, 8'h10, 8'h10}, '{8'h04, 8'h00, 8'h00},
               '{8'h0C, 8'h20, 8'h20}, '{8'h18, 8'h03, 8'h03},
               '{8'h18, 8'h00, 8'h00}, '{8'h1C, 8'hFF, 8'h00}};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1 chk("reset outputs", 16'h0020, {6'h00, oscStopReset, oscNmi,
         sharedNmi, clockOutPin, onchipSourceSelect, slowOscOff,
         fastOscEnable, fastOscChoice, subClockCpuSelect, mainClockStopped});
      // write protection holds while unlock is clear
      wr(8'h04, 8'h10);
      rd(8'h04, d);
      chk("protected write", 16'h0000, {8'h00, d});
      wr(8'h10, 8'h01);
      // ordinary register rows
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wd);
         rd(rows[i].addr, d);
         chk("register row", {8'h00, rows[i].exp}, {8'h00, d});
      end
      // clock output source selection
      wr(8'h0C, 8'h20);
      wr(8'h00, 8'h00);
      rises(n);
      chk("out main", 16'h0001, 16'(n >= 31 && n <= 33));
      wr(8'h0C, 8'h00);
      wr(8'h00, 8'h02);
      rises(n);
      chk("out div8", 16'h0001, 16'(n >= 3 && n <= 5));
      wr(8'h00, 8'h03);
      rises(n);
      chk("out div32", 16'h0001, 16'(n >= 1 && n <= 2));
      wr(8'h00, 8'h81);
      rises(n);
      chk("out sub", 16'h0001, 16'(n >= 7 && n <= 9));
      // lock freezes detect enable and cpu source
      wr(8'h00, 8'h00);
      wr(8'h14, 8'h01);
      wr(8'h08, 8'h01);
      rd(8'h08, d);
      chk("locked detEn", 16'h0000, {8'h00, d});
      wr(8'h00, 8'h80);
      rd(8'h00, d);
      chk("locked subCpu", 16'h0000, {8'h00, d});
      wr(8'h14, 8'h00);
      // detection disabled: a stop goes unnoticed
      osc(1'b0, 20);
      chk("disabled", 16'h0000, {14'h0000, oscStopReset,
         mainClockStopped});
      chk("disabled nmi", 16'h0000, 16'(nmiCnt));
      osc(1'b1, 10);
      // interrupt mode: stop, restart while flagged, clear, repeat
      wr(8'h04, 8'h10);
      wr(8'h18, 8'h03);
      wr(8'h00, 8'h80);
      wr(8'h08, 8'h81);
      osc(1'b0, 20);
      chk("stop nmi", 16'h0001, 16'(nmiCnt));
      chk("stop state", 16'h002F, {10'h000, onchipSourceSelect, slowOscOff,
         fastOscEnable, fastOscChoice, subClockCpuSelect,
         mainClockStopped});
      rd(8'h08, d);
      chk("stop flags", 16'h008F, {8'h00, d});
      osc(1'b1, 20);
      chk("flag blocks", 16'h0001, 16'(nmiCnt));
      rd(8'h08, d);
      chk("restart flags", 16'h0087, {8'h00, d});
      wr(8'h08, 8'h83);
      osc(1'b0, 20);
      chk("second stop", 16'h0002, 16'(nmiCnt));
      wr(8'h08, 8'h83);
      wr(8'h04, 8'h10);
      osc(1'b1, 20);
      chk("restart nmi", 16'h0003, 16'(nmiCnt));
      chk("restart state", 16'h0004, {13'h0000, onchipSourceSelect,
         slowOscOff, mainClockStopped});
      // software clears the on-chip source select; the sub clock CPU select stays set
      wr(8'h08, 8'h81);
      #1 chk("back to main", 16'h0000, {15'h0000, onchipSourceSelect});
      // other sources reach the shared request
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         {wdtIrq, voltMon1Irq, voltMon2Irq} <= 3'b001 << i;
         @(posedge clk);
         #1 chk("shared nmi", 16'h0001, {15'h0000, sharedNmi});
      end
      @(posedge clk);
      {wdtIrq, voltMon1Irq, voltMon2Irq} <= 3'b000;
      @(posedge clk);
      #1 chk("shared idle", 16'h0000, {15'h0000, sharedNmi});
      // reset mode: stop halts until voltage monitor 0 reset
      wr(8'h08, 8'h01);
      wr(8'h00, 8'h00);
      osc(1'b0, 20);
      chk("halted", 16'h0001, {15'h0000, oscStopReset});
      chk("no nmi halt", 16'h0003, 16'(nmiCnt));
      wr(8'h04, 8'h10);
      rd(8'h08, d);
      chk("halted read", 16'h0000, {8'h00, d});
      osc(1'b1, 10);
      chk("still halted", 16'h0001, {15'h0000, oscStopReset});
      @(posedge clk);
      voltMon0Rst <= 1'b1;
      @(posedge clk);
      voltMon0Rst <= 1'b0;
      @(posedge clk);
      #1 chk("halt released", 16'h0002, {14'h0000, onchipSourceSelect,
         oscStopReset});
      rd(8'h08, d);
      chk("after release", 16'h0002, {8'h00, d});
      summarize();
   end
endmodule
